// ### logic/ldrc_pkg.sv
// constants, codes and helper functions for the logical device resource config block
package ldrc_pkg;

  // ==========================================================================
  // configuration register indexes
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_BASE_HI  = 8'h60;
  localparam logic [7:0] IDX_BASE_LO  = 8'h61;
  localparam logic [7:0] IDX_IRQ_SEL  = 8'h70;
  localparam logic [7:0] IDX_IRQ_SEL2 = 8'h72;
  localparam logic [7:0] IDX_DMA_SEL  = 8'h74;

  // ==========================================================================
  // logical device numbers and internal slot numbers
  localparam logic [7:0] LDN_FLOPPY  = 8'h00;
  localparam logic [7:0] LDN_PRINTER = 8'h03;
  localparam logic [7:0] LDN_UART1   = 8'h04;
  localparam logic [7:0] LDN_UART2   = 8'h05;
  localparam logic [7:0] LDN_KBD     = 8'h07;
  localparam int         NUM_DEV     = 5;
  localparam int         NUM_SRC     = 6;       // keyboard has a second irq source
  localparam logic [2:0] DEV_FLP     = 3'd0;
  localparam logic [2:0] DEV_PRN     = 3'd1;
  localparam logic [2:0] DEV_U1      = 3'd2;
  localparam logic [2:0] DEV_U2      = 3'd3;
  localparam logic [2:0] DEV_KBD     = 3'd4;
  localparam logic [2:0] DEV_NONE    = 3'd7;

  // ==========================================================================
  // reset values and field layout
  localparam logic       RST_ACT   = 1'b0;
  localparam logic [7:0] RST_BASE  = 8'h00;
  localparam logic [3:0] RST_IRQ   = 4'h0;
  localparam logic [2:0] RST_DMA   = 3'h4;
  localparam int         IRQ_W     = 4;
  localparam int         DMA_W     = 3;
  localparam int         NUM_LVL   = 15;
  localparam int         NUM_CH    = 3;
  localparam logic [3:0] SMI_LEVEL = 4'h2;

  // ==========================================================================
  // address windows, only address bits 11..0 take part in decoding
  localparam logic [15:0] BASE_MIN      = 16'h0100;
  localparam logic [15:0] BASE_MAX8     = 16'h0FF8;
  localparam logic [15:0] BASE_MAX4     = 16'h0FFC;
  localparam logic [11:0] PRN_EXT_OFS   = 12'h400;
  localparam logic [1:0]  PRN_EXT_LAST  = 2'h2;
  localparam logic [2:0]  PRN_STD_LAST  = 3'h2;
  localparam logic [11:0] KBD_DATA_ADDR = 12'h060;
  localparam logic [11:0] KBD_CMD_ADDR  = 12'h064;
  localparam logic [14:0] PAR_IRQ_MASK  = 15'h0E7C;  // levels 3-7 and 10-12
  localparam logic [2:0]  ECR_MODE_ECP  = 3'h3;
  localparam logic [2:0]  ECR_MODE_EPP  = 3'h4;

  // base lies in [BASE_MIN, top] with the low align_bits zero
  function automatic logic ldrc_base_ok(input logic [15:0] base, input logic [15:0] top,
                                        input logic [15:0] align_mask);
    ldrc_base_ok = (base >= BASE_MIN) && (base <= top) && ((base & align_mask) == 16'h0000);
  endfunction : ldrc_base_ok

  // map a logical device number onto an internal slot
  function automatic logic [2:0] ldrc_dev_of(input logic [7:0] ldn);
    if (ldn == LDN_FLOPPY) ldrc_dev_of = DEV_FLP;
    else if (ldn == LDN_PRINTER) ldrc_dev_of = DEV_PRN;
    else if (ldn == LDN_UART1) ldrc_dev_of = DEV_U1;
    else if (ldn == LDN_UART2) ldrc_dev_of = DEV_U2;
    else if (ldn == LDN_KBD) ldrc_dev_of = DEV_KBD;
    else ldrc_dev_of = DEV_NONE;
  endfunction : ldrc_dev_of

endpackage : ldrc_pkg

// ### logic/ldrc_win_match.sv
// base address window compare for one relocatable logical device
`timescale 1ns/1ps
module ldrc_win_match
  import ldrc_pkg::*;
#(
  parameter logic [15:0] TOP   = BASE_MAX8,
  parameter logic [15:0] ALIGN = 16'h0007
) (
  input  wire logic [15:0] base,
  input  wire logic [15:0] addr,
  output logic             base_ok,
  output logic             hit4,
  output logic             hit8
);

  // ==========================================================================
  // compare only address bits 11..0 against the programmed base
  assign base_ok = ldrc_base_ok(base, TOP, ALIGN);
  assign hit4    = base_ok && (addr[11:2] == base[11:2]);
  // an 8-byte window only exists when the base sits on an 8-byte boundary
  assign hit8    = base_ok && (base[2] == 1'b0) && (addr[11:3] == base[11:3]);

endmodule : ldrc_win_match

// ### logic/ldrc_pin_stage.sv
// registered tri-state driver stage for a bank of request pins
`timescale 1ns/1ps
module ldrc_pin_stage #(
  parameter int N = 15
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [N-1:0] use_line,
  input  wire logic [N-1:0] val_line,
  output logic [N-1:0]      pin_out,
  output logic [N-1:0]      pin_oe_n
);

  // ==========================================================================
  // unused lines release the pin and park the output low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_out  <= '0;
      pin_oe_n <= '1;
    end else begin
      pin_out  <= val_line & use_line;
      pin_oe_n <= ~use_line;
    end
  end

endmodule : ldrc_pin_stage

// ### logic/ldrc_core.sv
// logical device resource configuration: base windows, irq and dma routing
`timescale 1ns/1ps
module ldrc_core
  import ldrc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        cfg_state,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_ldn,
  input  wire logic [7:0]  cfg_index,
  input  wire logic [7:0]  cfg_wdata,
  output logic [7:0]       cfg_rdata,
  input  wire logic [4:0]  pwr_wr,
  input  wire logic [4:0]  pwr_val,
  output logic [4:0]       dev_active,
  input  wire logic        io_cyc,
  input  wire logic [15:0] io_addr,
  output logic             floppy_sel,
  output logic             printer_sel,
  output logic             printer_epp_sel,
  output logic             printer_ext_sel,
  output logic             uart1_sel,
  output logic             uart2_sel,
  output logic             kbd_data_sel,
  output logic             kbd_cmd_sel,
  input  wire logic        floppy_dma_gate,
  input  wire logic        printer_irq_gate,
  input  wire logic [2:0]  ext_port_mode,
  input  wire logic        ext_port_service_flag,
  input  wire logic        ext_port_dma_gate,
  input  wire logic [3:0]  uart1_irq_enable_reg,
  input  wire logic        uart1_aux_output_two,
  input  wire logic [3:0]  uart2_irq_enable_reg,
  input  wire logic        uart2_aux_output_two,
  input  wire logic        uart2_ir_dma_gate,
  input  wire logic [5:0]  irq_req,
  input  wire logic [2:0]  dma_req,
  input  wire logic        serial_irq_mode,
  input  wire logic        smi_enable,
  input  wire logic        smi_event,
  output logic [15:1]      irq_out,
  output logic [15:1]      irq_oe_n,
  output logic [3:1]       dma_request_pin,
  output logic [3:1]       dma_oe_n
);

  // ==========================================================================
  // configuration storage
  logic [4:0]              act_reg;
  logic [4:0][7:0]         base_hi_reg;
  logic [4:0][7:0]         base_lo_reg;
  logic [5:0][IRQ_W-1:0]   irq_sel_reg;
  logic [4:0][DMA_W-1:0]   dma_sel_reg;
  logic [7:0]              rdata_next;
  logic [2:0]              dev;
  logic                    wr_ok;

  assign dev   = ldrc_dev_of(cfg_ldn);
  // writes outside the configuration state or to absent devices are dropped
  assign wr_ok = cfg_wr && cfg_state && (dev != DEV_NONE);

  // activate bit, also written by the power control path; the two stay one bit
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      act_reg <= {NUM_DEV{RST_ACT}};
    end else begin
      for (int d = 0; d < NUM_DEV; d++) begin
        if (wr_ok && (cfg_index == IDX_ACTIVATE) && (dev == 3'(d))) begin
          act_reg[d] <= cfg_wdata[0];
        end else if (pwr_wr[d]) begin
          act_reg[d] <= pwr_val[d];
        end
      end
    end
  end

  // base address bytes; the keyboard is fixed and has none
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      base_hi_reg <= {NUM_DEV{RST_BASE}};
      base_lo_reg <= {NUM_DEV{RST_BASE}};
    end else if (wr_ok && (dev != DEV_KBD)) begin
      if (cfg_index == IDX_BASE_HI) begin
        base_hi_reg[dev] <= cfg_wdata;
      end else if (cfg_index == IDX_BASE_LO) begin
        base_lo_reg[dev] <= cfg_wdata;
      end
    end
  end

  // irq level selects; slot 5 is the keyboard's second select
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_sel_reg <= {NUM_SRC{RST_IRQ}};
    end else if (wr_ok) begin
      if (cfg_index == IDX_IRQ_SEL) begin
        irq_sel_reg[dev] <= cfg_wdata[IRQ_W-1:0];
      end else if ((cfg_index == IDX_IRQ_SEL2) && (dev == DEV_KBD)) begin
        irq_sel_reg[NUM_SRC-1] <= cfg_wdata[IRQ_W-1:0];
      end
    end
  end

  // dma selects exist only for floppy, printer and second uart
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dma_sel_reg <= {NUM_DEV{RST_DMA}};
    end else if (wr_ok && (cfg_index == IDX_DMA_SEL)) begin
      if ((dev == DEV_FLP) || (dev == DEV_PRN) || (dev == DEV_U2)) begin
        dma_sel_reg[dev] <= cfg_wdata[DMA_W-1:0];
      end
    end
  end

  // ==========================================================================
  // read mux, reserved indexes and bits read as zero
  always_comb begin
    rdata_next = 8'h00;
    if (dev != DEV_NONE) begin
      if (cfg_index == IDX_ACTIVATE) begin
        rdata_next = {7'h00, act_reg[dev]};
      end else if ((cfg_index == IDX_BASE_HI) && (dev != DEV_KBD)) begin
        rdata_next = base_hi_reg[dev];
      end else if ((cfg_index == IDX_BASE_LO) && (dev != DEV_KBD)) begin
        rdata_next = base_lo_reg[dev];
      end else if (cfg_index == IDX_IRQ_SEL) begin
        rdata_next = {4'h0, irq_sel_reg[dev]};
      end else if ((cfg_index == IDX_IRQ_SEL2) && (dev == DEV_KBD)) begin
        rdata_next = {4'h0, irq_sel_reg[NUM_SRC-1]};
      end else if ((cfg_index == IDX_DMA_SEL) &&
                   ((dev == DEV_FLP) || (dev == DEV_PRN) || (dev == DEV_U2))) begin
        rdata_next = {5'h00, dma_sel_reg[dev]};
      end
    end
  end

  // read data updates on every read strobe, loading zero outside the configuration state, and then holds for the host
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_rd) begin
      cfg_rdata <= cfg_state ? rdata_next : 8'h00;
    end
  end

  // power state output mirrors the linked activate bit
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dev_active <= {NUM_DEV{RST_ACT}};
    end else begin
      dev_active <= act_reg;
    end
  end

  // ==========================================================================
  // I/O window decode
  logic [4:0] b_ok;
  logic [4:0] h4;
  logic [4:0] h8;
  logic       prn_ext_hit;
  logic [11:0] prn_ext_base;

  for (genvar g = 0; g < 4; g++) begin : g_win
    // printer alone may sit on a 4-byte boundary
    ldrc_win_match #(
      .TOP   ((g == 1) ? BASE_MAX4 : BASE_MAX8),
      .ALIGN ((g == 1) ? 16'h0003 : 16'h0007)
    ) u_win (
      .base    ({base_hi_reg[g], base_lo_reg[g]}),
      .addr    (io_addr),
      .base_ok (b_ok[g]),
      .hit4    (h4[g]),
      .hit8    (h8[g])
    );
  end
  assign b_ok[4] = 1'b0;
  assign h4[4]   = 1'b0;
  assign h8[4]   = 1'b0;

  // extended printer registers live 400h above the base; the sum wraps in 12 bits
  assign prn_ext_base = {base_hi_reg[DEV_PRN][3:0], base_lo_reg[DEV_PRN]} + PRN_EXT_OFS;
  assign prn_ext_hit  = b_ok[DEV_PRN] && (io_addr[11:2] == prn_ext_base[11:2]) &&
                        (io_addr[1:0] <= PRN_EXT_LAST);

  // selects are valid for the cycle after an active I/O cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      floppy_sel      <= 1'b0;
      printer_sel     <= 1'b0;
      printer_epp_sel <= 1'b0;
      printer_ext_sel <= 1'b0;
      uart1_sel       <= 1'b0;
      uart2_sel       <= 1'b0;
      kbd_data_sel    <= 1'b0;
      kbd_cmd_sel     <= 1'b0;
    end else begin
      floppy_sel      <= io_cyc && act_reg[DEV_FLP] && h8[DEV_FLP];
      // offset inside the 4-byte window, so a 4-aligned base still decodes
      printer_sel     <= io_cyc && act_reg[DEV_PRN] && h4[DEV_PRN] &&
                         (io_addr[1:0] <= PRN_STD_LAST[1:0]);
      printer_epp_sel <= io_cyc && act_reg[DEV_PRN] && h8[DEV_PRN] &&
                         (io_addr[2:0] > PRN_STD_LAST);
      printer_ext_sel <= io_cyc && act_reg[DEV_PRN] && prn_ext_hit;
      uart1_sel       <= io_cyc && act_reg[DEV_U1] && h8[DEV_U1];
      uart2_sel       <= io_cyc && act_reg[DEV_U2] && h8[DEV_U2];
      kbd_data_sel    <= io_cyc && act_reg[DEV_KBD] &&
                         (io_addr[11:0] == KBD_DATA_ADDR);
      kbd_cmd_sel     <= io_cyc && act_reg[DEV_KBD] &&
                         (io_addr[11:0] == KBD_CMD_ADDR);
    end
  end

  // ==========================================================================
  // interrupt routing, evaluated straight from the present configuration
  logic [5:0]  src_en;
  logic [5:0]  src_val;
  logic [5:0]  src_on;
  logic        ecp_mode;
  logic        prn_inv;
  logic [14:0] lvl_use;
  logic [14:0] lvl_val;
  logic [14:0] lvl_allow;

  assign ecp_mode = (ext_port_mode == ECR_MODE_ECP);
  // extended printer modes signal low-going; everything else high edge
  assign prn_inv  = ecp_mode || (ext_port_mode == ECR_MODE_EPP);
  // a device with a bad base is treated as not present
  assign src_on   = {act_reg[DEV_KBD], act_reg[DEV_KBD], act_reg[3:0] & b_ok[3:0]};

  always_comb begin
    src_en[DEV_FLP] = floppy_dma_gate;
    src_en[DEV_PRN] = printer_irq_gate && !(ecp_mode && ext_port_service_flag);
    src_en[DEV_U1]  = (|uart1_irq_enable_reg) && uart1_aux_output_two;
    src_en[DEV_U2]  = (|uart2_irq_enable_reg) && uart2_aux_output_two;
    src_en[4]       = 1'b1;
    src_en[5]       = 1'b1;
    src_val         = irq_req;
    src_val[DEV_PRN] = irq_req[DEV_PRN] ^ prn_inv;
  end

  // parallel pin mode offers only a subset of levels; level 2 yields to SMI
  always_comb begin
    lvl_allow = serial_irq_mode ? '1 : PAR_IRQ_MASK;
    lvl_allow[SMI_LEVEL - 4'h1] = lvl_allow[SMI_LEVEL - 4'h1] && !smi_enable;
    lvl_use = '0;
    lvl_val = '0;
    for (int l = 1; l <= NUM_LVL; l++) begin
      for (int s = 0; s < NUM_SRC; s++) begin
        if (src_on[s] && src_en[s] && (irq_sel_reg[s] == 4'(l))) begin
          lvl_use[l-1] = lvl_allow[l-1];
          lvl_val[l-1] = lvl_val[l-1] | src_val[s];
        end
      end
    end
    // management interrupt owns line 2 and is active low
    if (smi_enable) begin
      lvl_use[SMI_LEVEL - 4'h1] = 1'b1;
      lvl_val[SMI_LEVEL - 4'h1] = !smi_event;
    end
  end

  // unused lines float; select zero matches no level
  ldrc_pin_stage #(.N(NUM_LVL)) u_irq_pins (
    .mclk     (mclk),
    .rst      (rst),
    .use_line (lvl_use),
    .val_line (lvl_val),
    .pin_out  (irq_out),
    .pin_oe_n (irq_oe_n)
  );

  // ==========================================================================
  // dma routing
  logic [2:0] dma_en;
  logic [2:0][2:0] dma_slot;
  logic [2:0] ch_use;
  logic [2:0] ch_val;

  // device slot behind each dma source
  assign dma_slot = {DEV_U2, DEV_PRN, DEV_FLP};
  assign dma_en   = {uart2_ir_dma_gate, ext_port_dma_gate, floppy_dma_gate};

  always_comb begin
    ch_use = '0;
    ch_val = '0;
    for (int s = 0; s < NUM_CH; s++) begin
      for (int c = 1; c <= NUM_CH; c++) begin
        if (src_on[dma_slot[s]] && dma_en[s] &&
            (dma_sel_reg[dma_slot[s]] == 3'(c))) begin
          ch_use[c-1] = 1'b1;
          ch_val[c-1] = ch_val[c-1] | dma_req[s];
        end
      end
    end
  end

  ldrc_pin_stage #(.N(NUM_CH)) u_dma_pins (
    .mclk     (mclk),
    .rst      (rst),
    .use_line (ch_use),
    .val_line (ch_val),
    .pin_out  (dma_request_pin),
    .pin_oe_n (dma_oe_n)
  );

  // ==========================================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_locked_write;
    cfg_wr && !cfg_state;
  endsequence

  chk_cfg_locked_out: assert property (s_locked_write |=> $stable(act_reg) &&
    $stable(irq_sel_reg) && $stable(dma_sel_reg)) else $error("write outside config state");
  chk_no_irq_sel: assert property ((irq_sel_reg == '0) && !smi_enable |=> irq_oe_n == '1)
    else $error("irq line driven with no select");
  chk_dma_none_sel: assert property ((dma_sel_reg[0] >= 3'h4) && (dma_sel_reg[1] >= 3'h4) &&
    (dma_sel_reg[3] >= 3'h4) |=> dma_oe_n == '1) else $error("dma pin driven unselected");
  chk_par_irq_mask: assert property (##1 ((~irq_oe_n & ~PAR_IRQ_MASK &
    {15{!$past(serial_irq_mode)}}) == '0)) else $error("level unavailable in pin mode");
  chk_smi_line_two: assert property (smi_enable |=> !irq_oe_n[2] &&
    (irq_out[2] == !$past(smi_event))) else $error("line 2 not carrying smi");
  chk_kbd_fixed_io: assert property (io_cyc && act_reg[DEV_KBD] &&
    (io_addr[11:0] == KBD_CMD_ADDR) |=> kbd_cmd_sel && !kbd_data_sel)
    else $error("keyboard command port not decoded");
  chk_epp_align_8: assert property (base_lo_reg[DEV_PRN][2] |=> !printer_epp_sel)
    else $error("epp decoded on 4-byte base");
  chk_floppy_gate: assert property (!floppy_dma_gate && (irq_sel_reg[DEV_FLP] == 4'h3) &&
    (irq_sel_reg[5:1] == '0) |=> irq_oe_n[3]) else $error("floppy irq without dma gate");
  chk_act_linked: assert property (pwr_wr[DEV_U1] && !wr_ok ##1 1'b1 |=>
    dev_active[DEV_U1] == $past(pwr_val[DEV_U1], 2)) else $error("power bit not linked");

endmodule : ldrc_core

// ### tb/ldrc_sys_ctl.sv
// far side model: interrupt and dma controller inputs seeing the request lines
`timescale 1ns/1ps
module ldrc_sys_ctl (
  input  wire logic        mclk,
  input  wire logic [15:1] irq_out,
  input  wire logic [15:1] irq_oe_n,
  input  wire logic [3:1]  dma_request_pin,
  input  wire logic [3:1]  dma_oe_n,
  output logic [15:1]      irq_line,
  output logic [3:1]       dma_line
);
  // ==========================================================================
  // line resolution
  logic [15:1] irq_last = '0;
  logic [3:1]  dma_last = '0;
  // a released line shows the inverse of its last driven level, never a stale value
  always_ff @(posedge mclk) begin
    for (int i = 1; i <= 15; i++) begin
      if (irq_oe_n[i] === 1'b0) begin
        irq_last[i] <= irq_out[i];
      end
    end
    for (int i = 1; i <= 3; i++) begin
      if (dma_oe_n[i] === 1'b0) begin
        dma_last[i] <= dma_request_pin[i];
      end
    end
  end
  assign irq_line = (irq_out & ~irq_oe_n) | (~irq_last & irq_oe_n);
  assign dma_line = (dma_request_pin & ~dma_oe_n) | (~dma_last & dma_oe_n);
endmodule : ldrc_sys_ctl

// ### tb/tb_ldrc_core.sv
// self-checking bench for the resource configuration core
`timescale 1ns/1ps
module tb_ldrc_core
  import ldrc_pkg::*;
;
  logic mclk = 0, rst = 1, cfg_state = 1, cfg_wr = 0, cfg_rd = 0, io_cyc = 0;
  logic [7:0] cfg_ldn = 0, cfg_index = 0, cfg_wdata = 0, cfg_rdata;
  logic [4:0] pwr_wr = 0, pwr_val = 0, dev_active;
  logic [15:0] io_addr = 0;
  logic f_sel, p_sel, pe_sel, px_sel, u1_sel, u2_sel, kd_sel, kc_sel;
  logic fdg = 0, pig = 0, esf = 0, edg = 0, ua1 = 0, ua2 = 0, uid = 0, sim = 1, sme = 0, sev = 0;
  logic [2:0] epm = 0, dma_req = 0;
  logic [3:0] uie1 = 0, uie2 = 0;
  logic [5:0] irq_req = 0;
  logic [15:1] irq_out, irq_oe_n, irq_line;
  logic [3:1] dma_pin, dma_oe_n, dma_line;
  int num_errors = 0, comparisons = 0;
  // rows: logical device, index, write data, expected read
  localparam logic [31:0] ROWS [0:10] = '{32'h0360_0303, 32'h0361_7878, 32'h0460_0303,
    32'h0461_F8F8, 32'h0470_0404, 32'h0374_0303, 32'h0074_0202, 32'h0474_0100,
    32'h0760_0300, 32'h0371_5500, 32'h0472_0500};

  always #5 mclk = ~mclk;
  ldrc_core ldrc_core_i (.mclk(mclk), .rst(rst), .cfg_state(cfg_state), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_ldn(cfg_ldn), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .pwr_wr(pwr_wr), .pwr_val(pwr_val), .dev_active(dev_active),
    .io_cyc(io_cyc), .io_addr(io_addr), .floppy_sel(f_sel), .printer_sel(p_sel),
    .printer_epp_sel(pe_sel), .printer_ext_sel(px_sel), .uart1_sel(u1_sel),
    .uart2_sel(u2_sel), .kbd_data_sel(kd_sel), .kbd_cmd_sel(kc_sel), .floppy_dma_gate(fdg),
    .printer_irq_gate(pig), .ext_port_mode(epm), .ext_port_service_flag(esf),
    .ext_port_dma_gate(edg), .uart1_irq_enable_reg(uie1), .uart1_aux_output_two(ua1),
    .uart2_irq_enable_reg(uie2), .uart2_aux_output_two(ua2), .uart2_ir_dma_gate(uid),
    .irq_req(irq_req), .dma_req(dma_req), .serial_irq_mode(sim), .smi_enable(sme),
    .smi_event(sev), .irq_out(irq_out), .irq_oe_n(irq_oe_n), .dma_request_pin(dma_pin),
    .dma_oe_n(dma_oe_n));
  ldrc_sys_ctl ldrc_sys_ctl_i (.mclk(mclk), .irq_out(irq_out), .irq_oe_n(irq_oe_n),
    .dma_request_pin(dma_pin), .dma_oe_n(dma_oe_n), .irq_line(irq_line), .dma_line(dma_line));

  // ==========================================================================
  // compare and bus tasks
  task automatic cd(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected read data at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cd
  task automatic cp(input logic [14:0] got, input logic [14:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected pin value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cp
  // one-cycle strobes, launched and dropped on falling edges
  task automatic wr(input logic [7:0] l, input logic [7:0] i, input logic [7:0] d);
    @(negedge mclk);
    cfg_ldn = l; cfg_index = i; cfg_wdata = d; cfg_wr = 1;
    @(negedge mclk);
    cfg_wr = 0;
  endtask : wr
  task automatic rd(input logic [7:0] l, input logic [7:0] i, output logic [7:0] d);
    @(negedge mclk);
    cfg_ldn = l; cfg_index = i; cfg_rd = 1;
    @(negedge mclk);
    cfg_rd = 0;
    d = cfg_rdata;
  endtask : rd
  // select outputs are registered, so look one cycle after the address
  task automatic io(input logic [15:0] a, output logic [7:0] s);
    @(negedge mclk);
    io_cyc = 1; io_addr = a;
    @(negedge mclk);
    io_cyc = 0;
    s = {f_sel, p_sel, pe_sel, px_sel, u1_sel, u2_sel, kd_sel, kc_sel};
  endtask : io
  task automatic settle();
    repeat (2) @(negedge mclk);
  endtask : settle
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  // ==========================================================================
  // main sequence
  initial begin
    logic [7:0] d;
    repeat (8) @(negedge mclk);
    rst = 0;
    for (int r = 0; r < 11; r++) begin
      wr(ROWS[r][31:24], ROWS[r][23:16], ROWS[r][15:8]);
      rd(ROWS[r][31:24], ROWS[r][23:16], d);
      cd(d, ROWS[r][7:0]);
    end
    $display("test register table done");
    wr(8'h04, 8'h30, 8'h01); wr(8'h03, 8'h30, 8'h01); wr(8'h07, 8'h30, 8'h01);
    io(16'hF3F9, d); cd(d, 8'h08);
    io(16'h0400, d); cd(d, 8'h00);
    io(16'h0778, d); cd(d, 8'h10);
    io(16'h037B, d); cd(d, 8'h20);
    io(16'h0064, d); cd(d, 8'h01);
    io(16'h0060, d); cd(d, 8'h02);
    io(16'h037A, d); cd(d, 8'h40);
    wr(8'h03, 8'h61, 8'h7C);
    io(16'h037E, d); cd(d, 8'h40);
    io(16'h037F, d); cd(d, 8'h00);
    io(16'h077E, d); cd(d, 8'h10);
    $display("test io decode done");
    uie1 = 4'h1; ua1 = 1; irq_req = 6'h04; settle();
    cp(irq_oe_n, 15'h7FF7);
    cp(15'(irq_line[4]), 15'h0001);
    ua1 = 0; settle(); cp(irq_oe_n, 15'h7FFF);
    ua1 = 1; uie1 = 4'h0; settle(); cp(irq_oe_n, 15'h7FFF);
    uie1 = 4'h8; wr(8'h04, 8'h70, 8'h09); sim = 0; settle();
    cp(irq_oe_n, 15'h7FFF);
    sim = 1; settle(); cp(irq_oe_n, 15'h7EFF);
    wr(8'h04, 8'h70, 8'h00); settle(); cp(irq_oe_n, 15'h7FFF);
    sme = 1; sev = 1; settle();
    cp(15'({irq_oe_n[2], irq_out[2]}), 15'h0000);
    sme = 0; sev = 0;
    pig = 1; irq_req = 6'h02; wr(8'h03, 8'h70, 8'h05); settle();
    cp(irq_oe_n, 15'h7FEF);
    cp(15'(irq_out[5]), 15'h0001);
    epm = 3'h3; esf = 1; settle();
    cp(irq_oe_n, 15'h7FFF);
    esf = 0; settle();
    cp(15'({irq_oe_n[5], irq_out[5]}), 15'h0000);
    pig = 0; settle();
    cp(irq_oe_n, 15'h7FFF);
    epm = 3'h0; wr(8'h03, 8'h70, 8'h00);
    $display("test irq routing done");
    wr(8'h00, 8'h60, 8'h03); wr(8'h00, 8'h61, 8'hF0); wr(8'h00, 8'h30, 8'h01);
    fdg = 1; dma_req = 3'h1; settle();
    cp(15'({dma_oe_n, dma_line}), 15'h002F);
    fdg = 0; settle(); cp(15'(dma_oe_n), 15'h0007);
    fdg = 1; wr(8'h00, 8'h74, 8'h05); settle(); cp(15'(dma_oe_n), 15'h0007);
    fdg = 0; irq_req = 6'h01; wr(8'h00, 8'h70, 8'h03); settle();
    cp(irq_oe_n, 15'h7FFF);
    fdg = 1; settle();
    cp(irq_oe_n, 15'h7FFB);
    $display("test dma routing done");
    @(negedge mclk); pwr_wr = 5'h04;
    @(negedge mclk); pwr_wr = 5'h00;
    settle(); cp(15'(dev_active[2]), 15'h0000);
    rd(8'h04, 8'h30, d); cd(d, 8'h00);
    cfg_state = 0; wr(8'h04, 8'h70, 8'h07); rd(8'h04, 8'h70, d); cd(d, 8'h00);
    cfg_state = 1; rd(8'h04, 8'h70, d); cd(d, 8'h00);
    $display("test power and config state done");
    @(negedge mclk); rst = 1;
    @(negedge mclk); rst = 0;
    cp(irq_oe_n, 15'h7FFF);
    rd(8'h00, 8'h74, d); cd(d, 8'h04);
    rd(8'h03, 8'h60, d); cd(d, 8'h00);
    $display("test reset done");
    end_of_test();
  end

  // watchdog well beyond the 150 or so cycles the sequence needs
  initial begin
    #50000;
    num_errors++;
    $display("unexpected hang at %0t", $time);
    end_of_test();
  end
endmodule : tb_ldrc_core
